// ---- hw/ppc_map.svh ----
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// Clock and timing figures
`define PPC_CLK_PERIOD_NS 100
`define PPC_RST_MIN_NS    1000
`define PPC_RST_MIN_CYC   ((`PPC_RST_MIN_NS + `PPC_CLK_PERIOD_NS - 1) / `PPC_CLK_PERIOD_NS)
`define PPC_IRQ_HOLD_MS   500
`define PPC_IRQ_HOLD_CYC  ((`PPC_IRQ_HOLD_MS * 1000000) / `PPC_CLK_PERIOD_NS)
`define PPC_MDC_MAX_MHZ   25

// Field widths and reset values
`define PPC_RST_CNT_W     4
`define PPC_IRQ_TMR_W     23
`define PPC_ROLE_RST      1'h0

`endif

// ---- hw/ppc_pkg.sv ----
package ppc_pkg;

  // One received nibble with its qualifiers
  typedef struct packed {
    logic       valid;
    logic       error;
    logic [3:0] data;
  } ppc_rx_beat_type;

  // Interrupt pin state
  typedef enum logic [2:0] {
    PPC_IRQ_IDLE = 3'b001,
    PPC_IRQ_PEND = 3'b010,
    PPC_IRQ_HOLD = 3'b100
  } ppc_irq_state_type;

endpackage

// ---- hw/ppc_top.sv ----
`timescale 1ns/1ns
`include "ppc_map.svh"

module ppc_top #(
  parameter int IRQ_HOLD_CYC = `PPC_IRQ_HOLD_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     mode_rgmii,
  input  wire ppc_pkg::ppc_rx_beat_type rx_beat,
  output logic                          rx_clk_out,
  output logic                          rx_ctrl,
  output logic [3:0]                    rx_data,
  output logic                          rx_er,
  input  wire logic                     reset_low_in,
  output logic                          dev_reset,
  input  wire logic                     mdc,
  input  wire logic                     mdio_in,
  output logic                          mdio_out,
  output logic                          mdio_oe,
  input  wire logic                     mgmt_out_bit,
  input  wire logic                     mgmt_out_en,
  output logic                          mgmt_in_bit,
  output logic                          mgmt_in_stb,
  input  wire logic                     irq_role_sel,
  input  wire logic                     irq_enable,
  input  wire logic                     irq_event,
  input  wire logic                     irq_clear,
  input  wire logic                     reg_access_off,
  input  wire logic                     irq_or_powerdown_pin_in,
  output logic                          irq_or_powerdown_pin_out,
  output logic                          irq_or_powerdown_pin_oe,
  output logic                          powerdown_active
);

  // Pin synchronisers
  logic                            rst_s1, rst_s2, mode_s1, mode_s2;
  logic                            mdc_s1, mdc_s2, mdc_q, mdio_s1, mdio_s2;
  logic                            pin_s1, pin_s2;
  // Reset filter
  logic [`PPC_RST_CNT_W-1:0]       rst_cnt, next_rst_cnt;
  logic                            next_dev_reset;
  logic                            int_rst;
  // Receive path
  ppc_pkg::ppc_rx_beat_type        beat, next_beat;
  logic                            next_rx_clk, next_rx_ctrl, next_rx_er;
  logic [3:0]                      next_rx_data;
  // Management path
  logic                            mdc_rise, mdc_fall;
  logic                            next_mdio_oe, next_in_bit, next_in_stb;
  // Shared pin
  ppc_pkg::ppc_irq_state_type      irq_state, next_irq_state;
  logic [`PPC_IRQ_TMR_W-1:0]       irq_tmr, next_irq_tmr;
  logic                            role, next_role, next_pin_oe, next_pd;
  logic                            irq_hit;

  always_ff @(posedge clk) begin
    rst_s1  <= reset_low_in;
    rst_s2  <= rst_s1;
    mode_s1 <= mode_rgmii;
    mode_s2 <= mode_s1;
    mdc_s1  <= mdc;
    mdc_s2  <= mdc_s1;
    mdc_q   <= mdc_s2;
    mdio_s1 <= mdio_in;
    mdio_s2 <= mdio_s1;
    pin_s1  <= irq_or_powerdown_pin_in;
    pin_s2  <= pin_s1;
  end

  // count low time of reset pin
  always_comb begin
    next_rst_cnt   = rst_cnt;
    next_dev_reset = 1'b0;
    if (rst_s2) begin
      next_rst_cnt = '0;
    end else if (rst_cnt != `PPC_RST_CNT_W'(`PPC_RST_MIN_CYC)) begin
      next_rst_cnt = rst_cnt + `PPC_RST_CNT_W'(1);
    end
    if (!rst_s2 && next_rst_cnt == `PPC_RST_CNT_W'(`PPC_RST_MIN_CYC)) begin
      next_dev_reset = 1'b1;
    end
  end

  // Filter registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_cnt   <= '0;
      dev_reset <= 1'b0;
    end else begin
      rst_cnt   <= next_rst_cnt;
      dev_reset <= next_dev_reset;
    end
  end

  // Internal reset for receive, management and shared pin state; not the filter registers or the unreset pin synchronisers
  assign int_rst = sys_rst | dev_reset;

  always_comb begin
    next_rx_clk  = ~rx_clk_out;
    next_beat    = beat;
    next_rx_ctrl = rx_ctrl;
    next_rx_er   = rx_er;
    next_rx_data = rx_data;
    if (next_rx_clk) begin
      next_beat    = rx_beat;
      next_rx_data = rx_beat.data;
      next_rx_ctrl = rx_beat.valid;
      next_rx_er   = mode_s2 ? 1'b0 : rx_beat.error;
    end else if (mode_s2) begin
      next_rx_ctrl = beat.valid ^ beat.error;
    end
  end

  // Receive registers
  always_ff @(posedge clk) begin
    if (int_rst) begin
      rx_clk_out <= 1'b0;
      beat       <= '0;
      rx_ctrl    <= 1'b0;
      rx_er      <= 1'b0;
      rx_data    <= 4'h0;
    end else begin
      rx_clk_out <= next_rx_clk;
      beat       <= next_beat;
      rx_ctrl    <= next_rx_ctrl;
      rx_er      <= next_rx_er;
      rx_data    <= next_rx_data;
    end
  end

  assign mdc_rise = mdc_s2 & ~mdc_q;
  assign mdc_fall = ~mdc_s2 & mdc_q;

  // Sample on rise, change drive on fall
  always_comb begin
    next_in_stb  = mdc_rise;
    next_in_bit  = mdc_rise ? mdio_s2 : mgmt_in_bit;
    next_mdio_oe = mdio_oe;
    if (mdc_fall) begin
      next_mdio_oe = mgmt_out_en & ~mgmt_out_bit;
    end
  end

  // Management registers
  always_ff @(posedge clk) begin
    if (int_rst) begin
      mdio_oe     <= 1'b0;
      mdio_out    <= 1'b0;
      mgmt_in_bit <= 1'b0;
      mgmt_in_stb <= 1'b0;
    end else begin
      mdio_oe     <= next_mdio_oe;
      mdio_out    <= 1'b0;        // Open drain level
      mgmt_in_bit <= next_in_bit;
      mgmt_in_stb <= next_in_stb;
    end
  end

  // Enabled interrupt event
  assign irq_hit = irq_event & irq_enable;

  always_comb begin
    next_irq_state = irq_state;
    next_irq_tmr   = irq_tmr;
    next_role      = irq_role_sel;
    unique case (irq_state)
      ppc_pkg::PPC_IRQ_IDLE: begin
        if (irq_hit && reg_access_off) begin
          next_irq_state = ppc_pkg::PPC_IRQ_HOLD;
          next_irq_tmr   = `PPC_IRQ_TMR_W'(IRQ_HOLD_CYC);
        end else if (irq_hit) begin
          next_irq_state = ppc_pkg::PPC_IRQ_PEND;
        end
      end
      ppc_pkg::PPC_IRQ_PEND: begin
        // Set wins over clear
        if (irq_clear && !irq_hit) begin
          next_irq_state = ppc_pkg::PPC_IRQ_IDLE;
        end
      end
      ppc_pkg::PPC_IRQ_HOLD: begin
        if (irq_hit) begin
          next_irq_tmr = `PPC_IRQ_TMR_W'(IRQ_HOLD_CYC);
        end else if (irq_tmr == `PPC_IRQ_TMR_W'(1)) begin
          next_irq_state = ppc_pkg::PPC_IRQ_IDLE;
          next_irq_tmr   = '0;
        end else begin
          next_irq_tmr = irq_tmr - `PPC_IRQ_TMR_W'(1);
        end
      end
    endcase
    next_pin_oe = next_role & (next_irq_state != ppc_pkg::PPC_IRQ_IDLE);
    next_pd     = ~next_role & ~pin_s2;
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      irq_state                <= ppc_pkg::PPC_IRQ_IDLE;
      irq_tmr                  <= '0;
      role                     <= `PPC_ROLE_RST;
      irq_or_powerdown_pin_oe  <= 1'b0;
      irq_or_powerdown_pin_out <= 1'b0;
      powerdown_active         <= 1'b0;
    end else begin
      irq_state                <= next_irq_state;
      irq_tmr                  <= next_irq_tmr;
      role                     <= next_role;
      irq_or_powerdown_pin_oe  <= next_pin_oe;
      irq_or_powerdown_pin_out <= 1'b0;
      powerdown_active         <= next_pd;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (int_rst);

  a_mdio_never_high: assert property (mdio_out == 1'b0)
    else $error("management data driven high");
  a_mdio_drive_fall: assert property ($changed(mdio_oe) |-> $past(mdc_fall))
    else $error("management drive changed off falling edge");
  a_mdio_sample_rise: assert property (
    mdc_rise |=> mgmt_in_stb && mgmt_in_bit == $past(mdio_s2))
    else $error("management sample wrong");
  a_rgmii_rise_dv: assert property (
    mode_s2 && $rose(rx_clk_out) |-> rx_ctrl == beat.valid)
    else $error("rising half not data valid");
  a_rgmii_fall_xor: assert property (
    $past(mode_s2) && $fell(rx_clk_out) |-> rx_ctrl == (beat.valid ^ beat.error))
    else $error("falling half not valid xor error");
  a_mii_plain_dv: assert property (
    !$past(mode_s2) && $fell(rx_clk_out) |-> $stable(rx_ctrl) && $stable(rx_er))
    else $error("MII control changed on falling edge");
  a_mii_rx_error: assert property (
    !$past(mode_s2) && $rose(rx_clk_out) |-> rx_er == beat.error)
    else $error("MII receive error wrong");
  a_rx_data_sync: assert property ($fell(rx_clk_out) |-> $stable(rx_data))
    else $error("receive data changed on falling edge");
  a_reset_filter: assert property (@(posedge clk) disable iff (sys_rst)
    !rst_s2 [*8] ##1 !rst_s2 ##1 !rst_s2 |=> dev_reset)
    else $error("long reset low not honoured");
  a_pd_role_after: assert property (@(posedge clk) $past(dev_reset) |-> !role)
    else $error("role not power-down after reset");
  a_pd_enter: assert property (!irq_role_sel && !pin_s2 |=> powerdown_active)
    else $error("power-down not entered");
  a_irq_pull_low: assert property (irq_role_sel && irq_hit |=> irq_or_powerdown_pin_oe)
    else $error("interrupt pin not pulled");
  a_irq_self_clear: assert property (
    irq_state == ppc_pkg::PPC_IRQ_HOLD && irq_tmr == 1 && !irq_hit
    |=> irq_state == ppc_pkg::PPC_IRQ_IDLE)
    else $error("interrupt hold not self-cleared");

  c_rgmii_error: cover property (mode_s2 && beat.valid && beat.error && $fell(rx_clk_out));
  c_mdio_drive: cover property ($rose(mdio_oe));
  c_irq_hold: cover property (
    irq_state == ppc_pkg::PPC_IRQ_HOLD ##1 irq_state == ppc_pkg::PPC_IRQ_IDLE);
  c_powerdown: cover property ($rose(powerdown_active));

endmodule

// ---- verif/ppc_station.sv ----
`timescale 1ns/1ns

// Management station model: drives the management clock only inside frames
module ppc_station (
  output logic mdc,
  output logic mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic st_low;
  initial begin
    mdc    = 1'h0;
    st_low = 1'h0;
  end
  // open drain wire, pull-up wins when nobody pulls
  assign mdio_in = !(st_low | (mdio_oe & !mdio_out));
  // one bit per 800 ns, data set up while clock low
  task automatic frame(input logic [7:0] pat);
    #25; // Keep link edges off the system clock edges
    for (int i = 7; i >= 0; i--) begin
      #130 st_low = !pat[i]; // Station only pulls low, never high
      #270 mdc = 1'h1;
      #400 mdc = 1'h0;
    end
    #50 st_low = 1'h0;
  endtask
endmodule

// ---- verif/phy_pin_control_functions_test.sv ----
`timescale 1ns/1ns

module phy_pin_control_functions_test;
  logic clk = 0, sys_rst = 1, mode_rgmii = 0, reset_low_in = 1, pd_hold = 0;
  logic out_bit = 0, out_en = 0, role = 0, en = 0, ev = 0, clr = 0, acc_off = 0;
  ppc_pkg::ppc_rx_beat_type rx_beat = '0;
  logic       rx_clk_out, rx_ctrl, rx_er, dev_reset, mdc, mdio_in, mdio_out, mdio_oe;
  logic       in_bit, in_stb, pin_out, pin_oe, pd_act;
  logic [3:0] rx_data;
  logic [7:0] got = '0;
  int         miscompares = 0, compares = 0, wait_n;
  wire  [3:0] probe = {dev_reset, pin_oe, pd_act, rx_clk_out};

  always #50 clk = !clk;
  // Shared pin: pull-up, board and device may only pull low
  wire pin_lvl = !(pd_hold | (pin_oe & !pin_out));
  // Bits seen by the device at each management clock rise
  always @(posedge clk) if (in_stb === 1'h1) got <= {got[6:0], in_bit};

  ppc_top #(.IRQ_HOLD_CYC(20)) i_dut (.clk(clk), .sys_rst(sys_rst), .mode_rgmii(mode_rgmii),
    .rx_beat(rx_beat), .rx_clk_out(rx_clk_out), .rx_ctrl(rx_ctrl), .rx_data(rx_data),
    .rx_er(rx_er), .reset_low_in(reset_low_in), .dev_reset(dev_reset), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mgmt_out_bit(out_bit),
    .mgmt_out_en(out_en), .mgmt_in_bit(in_bit), .mgmt_in_stb(in_stb), .irq_role_sel(role),
    .irq_enable(en), .irq_event(ev), .irq_clear(clr), .reg_access_off(acc_off),
    .irq_or_powerdown_pin_in(pin_lvl), .irq_or_powerdown_pin_out(pin_out),
    .irq_or_powerdown_pin_oe(pin_oe), .powerdown_active(pd_act));
  ppc_station i_st (.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  task automatic close_out;
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic g, input logic e, input string m);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic chk4(input logic [3:0] g, input logic [3:0] e, input string m);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Bounded wait on one probe bit, sampled at falling clock edges
  task automatic await(input int i, input logic v, input int lim);
    for (wait_n = 0; wait_n < lim && probe[i] !== v; wait_n++) @(negedge clk);
    if (wait_n == lim) begin
      chk(1'h0, 1'h1, "wait timed out");
      close_out();
    end
  endtask
  // Beat launched at the receive clock fall that ends the high half, taken at the next receive clock rise
  task automatic rx(input logic [5:0] b, input logic lo, input logic er);
    @(negedge clk);
    await(0, 1'h1, 4);
    @(posedge clk) rx_beat <= ppc_pkg::ppc_rx_beat_type'(b);
    repeat (2) @(negedge clk);
    chk(rx_ctrl, b[5], "rx ctrl high half");
    chk4(rx_data, b[3:0], "rx data");
    chk(rx_er, er, "rx error");
    @(negedge clk);
    chk(rx_ctrl, lo, "rx ctrl low half");
  endtask
  task automatic irq_pulse;
    @(posedge clk) ev <= 1'h1;
    @(posedge clk) ev <= 1'h0;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    @(negedge clk);
    chk(pin_oe | mdio_oe | dev_reset, 1'h0, "outputs after reset");
    // MII then RGMII receive encoding
    rx(6'h35, 1'h1, 1'h1);
    rx(6'h0a, 1'h0, 1'h0);
    @(posedge clk) mode_rgmii <= 1'h1;
    repeat (4) @(posedge clk);
    rx(6'h3c, 1'h0, 1'h0);
    rx(6'h27, 1'h1, 1'h0);
    rx(6'h10, 1'h1, 1'h0);
    // Management bits sampled on the slow clock, then device pulls low
    i_st.frame(8'ha5);
    repeat (6) @(negedge clk);
    chk4(got[3:0], 4'h5, "mgmt bits low");
    chk4(got[7:4], 4'ha, "mgmt bits high");
    chk(mdio_oe, 1'h0, "mdio released");
    @(posedge clk) out_en <= 1'h1;
    i_st.frame(8'hff);
    repeat (6) @(negedge clk);
    chk(mdio_oe, 1'h1, "mdio pulled");
    chk(mdio_out, 1'h0, "mdio never high");
    chk(got[0], 1'h0, "wire low seen");
    @(posedge clk) out_en <= 1'h0;
    // Power-down role by default
    @(posedge clk) pd_hold <= 1'h1;
    await(1, 1'h1, 6);
    @(posedge clk) pd_hold <= 1'h0;
    await(1, 1'h0, 6);
    // Interrupt role: masked event, set, clear
    @(posedge clk) role <= 1'h1;
    irq_pulse();
    repeat (4) @(negedge clk);
    chk(pin_oe, 1'h0, "masked event");
    @(posedge clk) en <= 1'h1;
    irq_pulse();
    await(2, 1'h1, 3);
    chk(pin_lvl, 1'h0, "pin pulled low");
    chk(pin_out, 1'h0, "pin never driven high");
    repeat (30) @(negedge clk);
    chk(pin_oe, 1'h1, "held until clear");
    chk(pd_act, 1'h0, "no power-down in interrupt role");
    @(posedge clk) clr <= 1'h1;
    @(posedge clk) clr <= 1'h0;
    await(2, 1'h0, 3);
    // Self-clearing hold when register access is off
    @(posedge clk) acc_off <= 1'h1;
    irq_pulse();
    await(2, 1'h1, 3);
    await(2, 1'h0, 30);
    chk(wait_n >= 18 && wait_n <= 22, 1'h1, "hold length");
    @(posedge clk) acc_off <= 1'h0;
    // Short reset pulse ignored, long one clears pending interrupt
    irq_pulse();
    @(posedge clk) reset_low_in <= 1'h0;
    repeat (5) @(posedge clk);
    reset_low_in <= 1'h1;
    repeat (10) @(negedge clk);
    chk(dev_reset, 1'h0, "short reset ignored");
    @(posedge clk) reset_low_in <= 1'h0;
    await(3, 1'h1, 16);
    @(negedge clk);
    chk(pin_oe, 1'h0, "reset clears interrupt");
    @(posedge clk) reset_low_in <= 1'h1;
    await(3, 1'h0, 6);
    close_out();
  end
endmodule
